//--- logic/dbl_pkg.sv
package dbl_pkg;
    // bank count and address widths
    localparam int NUM_BANKS  = 4;
    localparam int BANK_W     = 2;
    localparam int ADDR_W     = 14;
    localparam int AP_BIT     = 10;
    localparam int CNT_W      = 8;
    // timing in ns and clocks (10 MHz reference)
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_RP_NS    = 15;
    localparam int T_RCD_NS   = 15;
    localparam int T_RFC_NS   = 105;
    localparam int T_WTR_NS   = 8;
    localparam int T_WR_NS    = 15;
    localparam int T_MRD_CK   = 2;
    localparam int WTR_MIN_CK = 2;
    localparam int AP_OTHER_CK = 1;
    localparam int RD_WR_EXTRA_CK = 2;
    localparam int CL_DEF     = 3;
    localparam int BL_DEF     = 4;
    function automatic int ck_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int T_RP_CK    = ck_up(T_RP_NS);
    localparam int T_RCD_CK   = ck_up(T_RCD_NS);
    localparam int T_RFC_CK   = ck_up(T_RFC_NS);
    localparam int T_WR_CK    = ck_up(T_WR_NS);
    localparam int T_WTR_CK   = (ck_up(T_WTR_NS) > WTR_MIN_CK) ? ck_up(T_WTR_NS) : WTR_MIN_CK;
    // command pin codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP  = 4'h7;
    localparam logic [3:0] CMD_ACT  = 4'h3;
    localparam logic [3:0] CMD_RD   = 4'h5;
    localparam logic [3:0] CMD_WR   = 4'h4;
    localparam logic [3:0] CMD_PRE  = 4'h2;
    localparam logic [3:0] CMD_REF  = 4'h1;
    localparam logic [3:0] CMD_LMR  = 4'h0;
    typedef enum logic [3:0] {
        OP_DESEL, OP_NOP, OP_ACT, OP_RD, OP_RDA, OP_WR, OP_WRA,
        OP_PRE, OP_PREA, OP_REF, OP_LMR
    } dbl_op_t;
    typedef enum logic [3:0] {
        BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
        BK_RDA, BK_WRA, BK_PRECHARGING
    } dbl_bank_t;
    typedef enum logic [1:0] { GL_NONE, GL_REFRESH, GL_MODE, GL_PREALL } dbl_glob_t;
endpackage

//--- logic/dbl_cmd_if.sv
`timescale 1ns/1ns
interface dbl_cmd_if;
    import dbl_pkg::*;
    logic                csN;
    logic                rasN;
    logic                casN;
    logic                weN;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   addr;
    modport ctrl (output csN, output rasN, output casN, output weN, output bank, output addr);
    modport dev  (input csN, input rasN, input casN, input weN, input bank, input addr);
endinterface

//--- logic/dbl_device.sv
`timescale 1ns/1ns
module dbl_device
    import dbl_pkg::*;
#(
    parameter int CL = CL_DEF,
    parameter int BL = BL_DEF
) (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    // command bus from controller
    dbl_cmd_if.dev                        cmd,
    // status
    output logic [NUM_BANKS*4-1:0]        bankState,
    output logic                          allIdle,
    output logic                          illegalCmd,
    output logic                          cmdTaken
);
    localparam int BURST_CK = BL / 2;

    dbl_bank_t        bankSt_r  [NUM_BANKS];
    logic [CNT_W-1:0] bankCnt_r [NUM_BANKS];
    logic [CNT_W-1:0] burstCnt_r;
    logic             burstRead_r;
    logic [CNT_W-1:0] wtrCnt_r;
    dbl_glob_t        glob_r;
    logic [CNT_W-1:0] globCnt_r;
    dbl_op_t          op;
    logic             bad;
    logic             anyBusy;
    dbl_bank_t        bankEff   [NUM_BANKS];
    logic             globBusy;

    function automatic dbl_op_t decode(input logic [3:0] pins, input logic ap);
        case (pins)
            CMD_NOP: decode = OP_NOP;
            CMD_ACT: decode = OP_ACT;
            CMD_RD:  decode = ap ? OP_RDA : OP_RD;
            CMD_WR:  decode = ap ? OP_WRA : OP_WR;
            CMD_PRE: decode = ap ? OP_PREA : OP_PRE;
            CMD_REF: decode = OP_REF;
            CMD_LMR: decode = OP_LMR;
            default: decode = OP_DESEL;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] ck(input int n);
        return CNT_W'((n < 1) ? 1 : n);
    endfunction

    // a counter at one means the timing is met at this edge, so a command
    // here is judged against the state that follows, not the one ending
    function automatic dbl_bank_t settle(input dbl_bank_t st, input logic [CNT_W-1:0] cnt);
        if (cnt != CNT_W'(1))
            return st;
        if (st inside {BK_ACTIVATING, BK_READ, BK_WRITE})
            return BK_ACTIVE;
        return BK_IDLE;
    endfunction

    always_comb begin
        op = cmd.csN ? OP_DESEL : decode({1'b0, cmd.rasN, cmd.casN, cmd.weN}, cmd.addr[AP_BIT]);
        globBusy = (glob_r != GL_NONE) && (globCnt_r > CNT_W'(1));
        anyBusy = (burstCnt_r != '0);
        for (int b = 0; b < NUM_BANKS; b++) begin
            bankEff[b] = settle(bankSt_r[b], bankCnt_r[b]);
            if (bankEff[b] != BK_IDLE)
                anyBusy = 1'b1;
        end
    end

    // legality check against the addressed bank and global state
    always_comb begin
        bad = 1'b0;
        if (op != OP_DESEL && op != OP_NOP) begin
            if (globBusy) begin
                bad = 1'b1;
            end else begin
                case (op)
                    OP_REF, OP_LMR: bad = anyBusy;
                    OP_PREA: begin
                        for (int b = 0; b < NUM_BANKS; b++) begin
                            if (bankEff[b] == BK_ACTIVATING || bankEff[b] == BK_RDA ||
                                bankEff[b] == BK_WRA)
                                bad = 1'b1;
                        end
                    end
                    OP_ACT: bad = bankEff[cmd.bank] != BK_IDLE;
                    OP_PRE: bad = !(bankEff[cmd.bank] inside
                                    {BK_IDLE, BK_ACTIVE, BK_READ, BK_WRITE, BK_PRECHARGING});
                    OP_RD, OP_RDA:
                        bad = !(bankEff[cmd.bank] inside {BK_ACTIVE, BK_READ, BK_WRITE}) ||
                              wtrCnt_r != '0 || (burstCnt_r != '0 && !burstRead_r);
                    OP_WR, OP_WRA:
                        bad = !(bankEff[cmd.bank] inside {BK_ACTIVE, BK_READ, BK_WRITE}) ||
                              (burstCnt_r != '0 && burstRead_r);
                    default: bad = 1'b0;
                endcase
            end
        end
    end

    // per-bank state and down-counters
    always_ff @(posedge ref_clk) begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (!resetn) begin
                bankSt_r[b]  <= BK_IDLE;
                bankCnt_r[b] <= '0;
            end else if (!bad && op == OP_PREA) begin
                bankSt_r[b]  <= BK_IDLE;
                bankCnt_r[b] <= '0;
            end else if (!bad && cmd.bank == BANK_W'(b) &&
                         op inside {OP_ACT, OP_RD, OP_RDA, OP_WR, OP_WRA, OP_PRE}) begin
                case (op)
                    OP_ACT: begin
                        bankSt_r[b]  <= BK_ACTIVATING;
                        bankCnt_r[b] <= ck(T_RCD_CK);
                    end
                    OP_RD: begin
                        bankSt_r[b]  <= BK_READ;
                        bankCnt_r[b] <= ck(BURST_CK);
                    end
                    OP_WR: begin
                        bankSt_r[b]  <= BK_WRITE;
                        bankCnt_r[b] <= ck(CL - 1 + BURST_CK);
                    end
                    OP_RDA: begin
                        bankSt_r[b]  <= BK_RDA;
                        bankCnt_r[b] <= ck(BURST_CK + T_RP_CK);
                    end
                    OP_WRA: begin
                        bankSt_r[b]  <= BK_WRA;
                        bankCnt_r[b] <= ck(CL - 1 + BURST_CK + T_WR_CK + T_RP_CK);
                    end
                    default: begin
                        bankSt_r[b]  <= BK_PRECHARGING;
                        bankCnt_r[b] <= ck(T_RP_CK);
                    end
                endcase
            end else if (bankCnt_r[b] > CNT_W'(1)) begin
                bankCnt_r[b] <= bankCnt_r[b] - CNT_W'(1);
            end else if (bankCnt_r[b] == CNT_W'(1)) begin
                bankCnt_r[b] <= '0;
                bankSt_r[b]  <= bankEff[b];
            end
        end
    end

    // global states: refresh, mode load, precharge all
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            glob_r    <= GL_NONE;
            globCnt_r <= '0;
        end else if (!bad && op == OP_REF) begin
            glob_r    <= GL_REFRESH;
            globCnt_r <= ck(T_RFC_CK);
        end else if (!bad && op == OP_LMR) begin
            glob_r    <= GL_MODE;
            globCnt_r <= ck(T_MRD_CK);
        end else if (!bad && op == OP_PREA) begin
            glob_r    <= GL_PREALL;
            globCnt_r <= ck(T_RP_CK);
        end else if (globCnt_r > CNT_W'(1)) begin
            globCnt_r <= globCnt_r - CNT_W'(1);
        end else begin
            globCnt_r <= '0;
            glob_r    <= GL_NONE;
        end
    end

    // shared data bus tracking for turnaround spacing
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            burstCnt_r  <= '0;
            burstRead_r <= 1'b0;
            wtrCnt_r    <= '0;
        end else begin
            if (!bad && op inside {OP_RD, OP_RDA}) begin
                burstCnt_r  <= ck(BURST_CK + RD_WR_EXTRA_CK - 1);
                burstRead_r <= 1'b1;
            end else if (!bad && op inside {OP_WR, OP_WRA}) begin
                burstCnt_r  <= ck(BURST_CK - 1);
                burstRead_r <= 1'b0;
            end else if (burstCnt_r != '0) begin
                burstCnt_r <= burstCnt_r - CNT_W'(1);
            end
            if (!bad && op inside {OP_WR, OP_WRA})
                wtrCnt_r <= ck(CL - 1 + BURST_CK + T_WTR_CK - 1);
            else if (wtrCnt_r != '0)
                wtrCnt_r <= wtrCnt_r - CNT_W'(1);
        end
    end

    // registered status outputs
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            bankState  <= '0;
            allIdle    <= 1'b1;
            illegalCmd <= 1'b0;
            cmdTaken   <= 1'b0;
        end else begin
            for (int b = 0; b < NUM_BANKS; b++)
                bankState[b*4 +: 4] <= bankSt_r[b];
            allIdle    <= !anyBusy && !globBusy;
            illegalCmd <= bad;
            cmdTaken   <= !bad && op != OP_DESEL && op != OP_NOP;
        end
    end
endmodule

//--- logic/dbl_controller.sv
`timescale 1ns/1ns
// controller end: drives one requested command per strobe, else nop
module dbl_controller
    import dbl_pkg::*;
(
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    // user request
    input  wire logic                reqValid,
    input  wire logic [3:0]          reqPins,
    input  wire logic [BANK_W-1:0]   reqBank,
    input  wire logic [ADDR_W-1:0]   reqAddr,
    output logic                     reqDone,
    // command bus to device
    dbl_cmd_if.ctrl                  cmd
);
    logic [3:0]        pins_r;
    logic [BANK_W-1:0] bank_r;
    logic [ADDR_W-1:0] addr_r;

    assign cmd.csN  = pins_r[3];
    assign cmd.rasN = pins_r[2];
    assign cmd.casN = pins_r[1];
    assign cmd.weN  = pins_r[0];
    assign cmd.bank = bank_r;
    assign cmd.addr = addr_r;

    // spacing is the user's duty; this end only frames commands
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pins_r  <= CMD_NOP;
            bank_r  <= '0;
            addr_r  <= '0;
            reqDone <= 1'b0;
        end else begin
            pins_r  <= reqValid ? reqPins : CMD_NOP;
            bank_r  <= reqValid ? reqBank : bank_r;
            addr_r  <= reqValid ? reqAddr : addr_r;
            reqDone <= reqValid;
        end
    end
endmodule

//--- tb/dbl_monitor.sv
`timescale 1ns/1ns
module dbl_monitor
    import dbl_pkg::*;
#(
    parameter int CL = CL_DEF,
    parameter int BL = BL_DEF
) (
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              resetn,
    // command wire
    input wire logic              csN,
    input wire logic              rasN,
    input wire logic              casN,
    input wire logic              weN,
    input wire logic [BANK_W-1:0] bank,
    input wire logic [ADDR_W-1:0] addr,
    // device answers
    input wire logic              illegalCmd,
    input wire logic              cmdTaken
);
    // windows start on the edge after the command, hence the minus two
    localparam int RW_GAP = BL / 2 + RD_WR_EXTRA_CK - 2;
    localparam int WR_GAP = CL - 1 + BL / 2 + T_WTR_CK - 2;
    logic [3:0] pins;
    logic       exe;
    assign pins = {csN, rasN, casN, weN};
    assign exe  = !csN && (pins != CMD_NOP);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_rda;
        pins == CMD_RD && addr[AP_BIT] ##1 cmdTaken;
    endsequence
    sequence s_wra;
        pins == CMD_WR && addr[AP_BIT] ##1 cmdTaken;
    endsequence
    a_desel_ignored: assert property (csN |=> !cmdTaken && !illegalCmd)
        else $error("deselect drew a response");
    a_nop_silent: assert property (pins == CMD_NOP |=> !(cmdTaken || illegalCmd))
        else $error("nop drew a response");
    a_exec_answered: assert property (exe |=> cmdTaken != illegalCmd)
        else $error("command not answered exactly once");
    a_refresh_busy: assert property (pins == CMD_REF ##1 (cmdTaken && exe) |=> illegalCmd)
        else $error("command accepted during refresh");
    a_mode_busy: assert property (pins == CMD_LMR ##1 (cmdTaken && exe) |=> illegalCmd)
        else $error("command accepted during mode load");
    a_rda_write: assert property (s_rda ##[0:RW_GAP] pins == CMD_WR |=> illegalCmd)
        else $error("write too soon after read with precharge");
    a_wra_read: assert property (s_wra ##[0:WR_GAP] pins == CMD_RD |=> illegalCmd)
        else $error("read too soon after write with precharge");
    a_write_read: assert property (pins == CMD_WR ##1 (cmdTaken && pins == CMD_RD) |=> illegalCmd)
        else $error("read accepted right after write");
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top import dbl_pkg::*;;
    logic                   ref_clk = 1'b0;
    logic                   resetn;
    logic                   reqValid;
    logic [3:0]             reqPins;
    logic [BANK_W-1:0]      reqBank;
    logic [ADDR_W-1:0]      reqAddr;
    logic                   reqDone;
    logic [NUM_BANKS*4-1:0] bankState;
    logic                   allIdle;
    logic                   illegalCmd;
    logic                   cmdTaken;
    int                     n_mismatch = 0;
    int                     check_count = 0;
    int                     cyc = 0;
    int                     b;
    int                     opn[NUM_BANKS];
    int                     bb[NUM_BANKS];
    int                     gb = 0;
    int                     rb = 0;
    int                     wb = 0;
    int                     eq[$];
    always #50 ref_clk = ~ref_clk;
    dbl_cmd_if cmdBus ();
    dbl_controller dbl_controller_i (.ref_clk(ref_clk), .resetn(resetn), .reqValid(reqValid),
        .reqPins(reqPins), .reqBank(reqBank), .reqAddr(reqAddr), .reqDone(reqDone), .cmd(cmdBus));
    dbl_device #(.CL(CL_DEF), .BL(BL_DEF)) dbl_device_i (.ref_clk(ref_clk), .resetn(resetn),
        .cmd(cmdBus), .bankState(bankState), .allIdle(allIdle), .illegalCmd(illegalCmd),
        .cmdTaken(cmdTaken));
    dbl_monitor #(.CL(CL_DEF), .BL(BL_DEF)) dbl_monitor_i (.ref_clk(ref_clk), .resetn(resetn),
        .csN(cmdBus.csN), .rasN(cmdBus.rasN), .casN(cmdBus.casN), .weN(cmdBus.weN),
        .bank(cmdBus.bank), .addr(cmdBus.addr), .illegalCmd(illegalCmd), .cmdTaken(cmdTaken));
    task automatic report_and_stop;
        if (n_mismatch == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // 0 no answer, 1 accepted, 2 refused; a counter c blocks the next c-1 edges
    function automatic int model(logic [3:0] p, int k, logic ap);
        int ok;
        int nb;
        int no;
        nb = bb.sum();
        no = opn.sum();
        if (p[3] || p == CMD_NOP) return 0;
        case (p)
            CMD_ACT: ok = !opn[k] && bb[k] == 0;
            CMD_RD:  ok = opn[k] && bb[k] == 0 && wb == 0;
            CMD_WR:  ok = opn[k] && bb[k] == 0 && rb == 0;
            CMD_PRE: ok = ap ? nb == 0 : bb[k] == 0;
            default: ok = nb == 0 && no == 0 && rb == 0 && wb == 0;
        endcase
        if (gb > 0 || !ok) return 2;
        case (p)
            CMD_ACT: begin
                opn[k] = 1;
                bb[k] = T_RCD_CK;
            end
            CMD_RD: begin
                rb = BL_DEF / 2 + RD_WR_EXTRA_CK;
                if (ap) begin
                    opn[k] = 0;
                    bb[k] = BL_DEF / 2 + T_RP_CK;
                end
            end
            CMD_WR: begin
                wb = CL_DEF - 1 + BL_DEF / 2 + T_WTR_CK;
                if (ap) begin
                    opn[k] = 0;
                    bb[k] = CL_DEF - 1 + BL_DEF / 2 + T_WR_CK + T_RP_CK;
                end
            end
            CMD_PRE: begin
                if (ap) opn = '{default: 0};
                if (ap) gb = T_RP_CK;
                else opn[k] = 0;
                if (!ap) bb[k] = T_RP_CK;
            end
            CMD_REF: gb = T_RFC_CK;
            default: gb = T_MRD_CK;
        endcase
        return 1;
    endfunction
    task automatic step(input logic [3:0] p, input int k = 0, input logic ap = 1'b0);
        int e;
        e = model(p, k, ap);
        reqValid = (p != CMD_NOP);
        reqPins = p;
        reqBank = k[BANK_W-1:0];
        reqAddr = ADDR_W'($urandom);
        reqAddr[AP_BIT] = ap;
        foreach (bb[i]) bb[i] -= (bb[i] > 0);
        gb -= (gb > 0);
        rb -= (rb > 0);
        wb -= (wb > 0);
        eq.push_back(e);
        @(negedge ref_clk);
        chk("reqDone", reqDone, reqValid);
        if (eq.size() > 1) begin
            e = eq.pop_front();
            chk("answer", {illegalCmd, cmdTaken}, e[1:0]);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) step(CMD_NOP);
    endtask
    initial begin
        void'($urandom(59));
        resetn = 1'b0;
        reqValid = 1'b0;
        reqPins = CMD_NOP;
        reqBank = '0;
        reqAddr = '0;
        repeat (20) @(negedge ref_clk);
        resetn = 1'b1;
        step(CMD_ACT, 0);
        step(CMD_ACT, 1);
        step(CMD_ACT, 2);
        step(CMD_REF);
        idle(2);
        step(CMD_RD, 0, 1'b1);
        step(CMD_WR, 1);
        idle(3);
        step(CMD_WR, 1, 1'b1);
        step(CMD_RD, 2);
        step(CMD_PRE, 0);
        idle(6);
        step(CMD_WR, 2);
        step(CMD_RD, 2);
        idle(7);
        step(CMD_RD, 2);
        step(CMD_WR, 2);
        idle(2);
        step(CMD_PRE, 2);
        idle(3);
        step(CMD_ACT, 3);
        step(CMD_RD, 3, 1'b1);
        step(CMD_PRE, 0, 1'b1);
        idle(2);
        step(CMD_PRE, 0, 1'b1);
        idle(3);
        step(CMD_REF);
        step(CMD_ACT, 3);
        idle(3);
        step(CMD_LMR);
        step(CMD_ACT, 3);
        idle(3);
        step({1'b1, 3'($urandom)});
        for (int i = 0; i < 6; i++) begin
            b = $urandom % NUM_BANKS;
            step(CMD_ACT, b);
            idle(2);
            step(CMD_ACT, b);
            step(($urandom % 2) ? CMD_RD : CMD_WR, b, 1'($urandom));
            step(CMD_ACT, b);
            idle(7);
            step(CMD_PRE, b);
            idle(3);
        end
        idle(2);
        chk("allIdle", allIdle, 16'h0001);
        chk("bankState", bankState, 16'h0000);
        report_and_stop();
    end
endmodule
